// ---- verilog/acr_pkg.sv ----
// Shared constants and carrier types for the converter result and trigger registers
package acr_pkg;
  localparam int          ACR_ADDR_W  = 5;
  localparam int          ACR_DATA_W  = 32;
  localparam int          ACR_REG_W   = 8;
  localparam int          ACR_RES_W   = 10;
  localparam int          ACR_SRC_N   = 32;
  localparam int          ACR_SEL_W   = 5;
  localparam int          ACR_PAD_W   = ACR_DATA_W - ACR_REG_W;

  // Byte addresses, one aligned word each
  localparam logic [4:0]  ACR_OFS_CTRL_A = 5'h00;
  localparam logic [4:0]  ACR_OFS_CTRL_B = 5'h04;
  localparam logic [4:0]  ACR_OFS_TRIG   = 5'h08;
  localparam logic [4:0]  ACR_OFS_RES_HI = 5'h0C;
  localparam logic [4:0]  ACR_OFS_RES_LO = 5'h10;

  // Field positions
  localparam int          ACR_CTRL_A_ON_BIT  = 0;
  localparam int          ACR_CTRL_A_CHS_LSB = 2;
  localparam int          ACR_CTRL_A_CHS_MSB = 7;
  localparam int          ACR_CTRL_B_FMT_BIT = 7;
  localparam int          ACR_CTRL_B_CLK_LSB = 4;
  localparam int          ACR_CTRL_B_CLK_MSB = 6;
  localparam int          ACR_CTRL_B_REF_LSB = 0;
  localparam int          ACR_CTRL_B_REF_MSB = 1;
  localparam int          ACR_BE_LANE0       = 0;

  // Implemented-bit masks and reset values
  localparam logic [7:0]  ACR_CTRL_A_MASK = 8'hFD;
  localparam logic [7:0]  ACR_CTRL_B_MASK = 8'hF3;
  localparam logic [7:0]  ACR_CTRL_A_RST  = 8'h00;
  localparam logic [7:0]  ACR_CTRL_B_RST  = 8'h00;
  localparam logic [4:0]  ACR_TRIG_RST    = 5'h00;
  localparam logic [31:0] ACR_SRC_PREV_RST = 32'hFFFFFFFF;
  localparam logic [5:0]  ACR_RES_FILL    = 6'h00;
  localparam logic [31:0] ACR_RD_ZERO     = 32'h00000000;

  // Completed conversion from the analog core
  typedef struct packed {
    logic                 done;
    logic [ACR_RES_W-1:0] result;
  } acr_conv_t;

  // Avalon request bundled for decode
  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [ACR_ADDR_W-1:0] address;
    logic [ACR_DATA_W-1:0] writedata;
    logic [3:0]            byteenable;
  } acr_avs_req_t;
endpackage

// ---- verilog/acr_edge_sel.sv ----
// Per-source rising-edge detection and selection of the auto-conversion trigger
`timescale 1ns/100ps
module acr_edge_sel (
  input  wire logic                          clk_in,
  input  wire logic                          srst_in,
  input  wire logic [acr_pkg::ACR_SRC_N-1:0] sources_in,
  input  wire logic [acr_pkg::ACR_SEL_W-1:0] sel_in,
  output logic                               start_out
);
  logic [acr_pkg::ACR_SRC_N-1:0] prev;
  logic [acr_pkg::ACR_SRC_N-1:0] rise;
  wire                           src_now  = sources_in[sel_in];
  wire                           src_prev = prev[sel_in];

  // History kept for every source so a selection change never fakes an edge
  genvar i;
  generate
    for (i = 0; i < acr_pkg::ACR_SRC_N; i++) begin : g_src
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          prev[i] <= acr_pkg::ACR_SRC_PREV_RST[i];
        end else begin
          prev[i] <= sources_in[i];
        end
      end
      assign rise[i] = sources_in[i] & ~prev[i]; // [RQ3]
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      start_out <= 1'b0;
    end else begin
      start_out <= rise[sel_in]; // [RQ3]
    end
  end

  rise_starts_a: assert property ( // [RQ3]
    @(posedge clk_in) disable iff (srst_in)
    (src_now && !src_prev) |=> start_out)
    else $error("Rising edge of selected source gave no start");

  level_no_start_a: assert property ( // [RQ3]
    @(posedge clk_in) disable iff (srst_in)
    (src_now && src_prev) |=> !start_out)
    else $error("Steady high source started a conversion");
endmodule

// ---- verilog/acr_regs.sv ----
// Converter control, trigger select and result registers behind an Avalon-MM slave
`timescale 1ns/100ps
// Functional notes
// RQ1: A five-bit trigger select field in the low bits of the trigger register picks the source.
// RQ2: Trigger register bits seven to five read as zero and ignore writes.
// RQ3: An automatic conversion starts only on a rising edge of the selected source.
// RQ4: With left format the high result byte holds result bits nine to two.
// RQ5: With left format result bits one and zero sit in bits seven and six of the low byte.
// RQ6: Software must not rely on the six low bits of the low byte in left format.
// RQ7: With right format result bits nine and eight sit in bits one and zero of the high byte.
// RQ8: With right format the low result byte holds result bits seven to zero.
// RQ9: Result bytes are read/write, unknown at power-up and kept through any other reset.
// RQ10: A finished conversion updates both result bytes at once using the current format.
module acr_regs (
  input  wire logic                             clk_in,
  input  wire logic                             srst_in,
  input  wire logic [acr_pkg::ACR_ADDR_W-1:0]   avs_address_in,
  input  wire logic                             avs_read_in,
  input  wire logic                             avs_write_in,
  input  wire logic [acr_pkg::ACR_DATA_W-1:0]   avs_writedata_in,
  input  wire logic [3:0]                       avs_byteenable_in,
  output logic      [acr_pkg::ACR_DATA_W-1:0]   avs_readdata_out,
  output logic                                  avs_waitrequest_out,
  input  wire logic [acr_pkg::ACR_SRC_N-1:0]    trig_sources_in,
  input  wire acr_pkg::acr_conv_t               conv_in,
  output logic                                  conv_start_out,
  output logic                                  converter_on_out,
  output logic      [5:0]                       channel_sel_out,
  output logic                                  result_format_sel_out,
  output logic      [2:0]                       conversion_clock_sel_out,
  output logic      [1:0]                       positive_reference_sel_out
);
  acr_pkg::acr_avs_req_t              req;
  logic [acr_pkg::ACR_REG_W-1:0]      converter_ctrl_a;
  logic [acr_pkg::ACR_REG_W-1:0]      converter_ctrl_b;
  logic [acr_pkg::ACR_SEL_W-1:0]      trigger_source_sel;
  logic [acr_pkg::ACR_REG_W-1:0]      result_high_byte;
  logic [acr_pkg::ACR_REG_W-1:0]      result_low_byte;
  logic                               rd_was_trig;

  assign req.read       = avs_read_in;
  assign req.write      = avs_write_in;
  assign req.address    = avs_address_in;
  assign req.writedata  = avs_writedata_in;
  assign req.byteenable = avs_byteenable_in;

  // Address decode
  wire hit_ctrl_a = (req.address == acr_pkg::ACR_OFS_CTRL_A);
  wire hit_ctrl_b = (req.address == acr_pkg::ACR_OFS_CTRL_B);
  wire hit_trig   = (req.address == acr_pkg::ACR_OFS_TRIG);
  wire hit_res_hi = (req.address == acr_pkg::ACR_OFS_RES_HI);
  wire hit_res_lo = (req.address == acr_pkg::ACR_OFS_RES_LO);

  // A request is taken on the edge where waitrequest is already low
  wire req_any    = req.read | req.write;
  wire req_first  = req_any & avs_waitrequest_out;
  wire lane0      = req.byteenable[acr_pkg::ACR_BE_LANE0];
  wire wr_accept  = req.write & ~avs_waitrequest_out & lane0;
  wire wr_ctrl_a  = wr_accept & hit_ctrl_a;
  wire wr_ctrl_b  = wr_accept & hit_ctrl_b;
  wire wr_trig    = wr_accept & hit_trig;
  wire wr_res_hi  = wr_accept & hit_res_hi;
  wire wr_res_lo  = wr_accept & hit_res_lo;
  wire [7:0] wr_byte = req.writedata[acr_pkg::ACR_REG_W-1:0];

  // Read data; unmapped addresses return zero
  wire [7:0] rd_trig_byte = {3'h0, trigger_source_sel}; // [RQ2]
  wire [7:0] rd_byte =
    hit_ctrl_a ? converter_ctrl_a :
    hit_ctrl_b ? converter_ctrl_b :
    hit_trig   ? rd_trig_byte     :
    hit_res_hi ? result_high_byte :
    hit_res_lo ? result_low_byte  : 8'h00;
  wire [31:0] rd_word = {{acr_pkg::ACR_PAD_W{1'b0}}, rd_byte};

  // Result formatting, sampled with the format bit of the completing cycle
  wire fmt_right = converter_ctrl_b[acr_pkg::ACR_CTRL_B_FMT_BIT];
  wire [9:0] res = conv_in.result;
  wire [7:0] left_hi  = res[9:2]; // [RQ4]
  wire [7:0] left_lo  = {res[1:0], acr_pkg::ACR_RES_FILL}; // [RQ5]
  wire [7:0] right_hi = {acr_pkg::ACR_RES_FILL, res[9:8]}; // [RQ7]
  wire [7:0] right_lo = res[7:0]; // [RQ8]
  wire [7:0] fmt_hi   = fmt_right ? right_hi : left_hi;
  wire [7:0] fmt_lo   = fmt_right ? right_lo : left_lo;
  wire [15:0] fmt_word = {fmt_hi, fmt_lo};

  // Hardware completion wins over a software write in the same cycle
  wire [7:0] next_result_high_byte =
    conv_in.done ? fmt_hi : (wr_res_hi ? wr_byte : result_high_byte); // [RQ10]
  wire [7:0] next_result_low_byte =
    conv_in.done ? fmt_lo : (wr_res_lo ? wr_byte : result_low_byte); // [RQ10]

  // One wait state: low for exactly one cycle per request
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~req_first;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      avs_readdata_out <= acr_pkg::ACR_RD_ZERO;
      rd_was_trig      <= 1'b0;
    end else if (req_first) begin
      avs_readdata_out <= req.read ? rd_word : acr_pkg::ACR_RD_ZERO;
      rd_was_trig      <= req.read & hit_trig;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      converter_ctrl_a <= acr_pkg::ACR_CTRL_A_RST;
    end else if (wr_ctrl_a) begin
      converter_ctrl_a <= wr_byte & acr_pkg::ACR_CTRL_A_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      converter_ctrl_b <= acr_pkg::ACR_CTRL_B_RST;
    end else if (wr_ctrl_b) begin
      converter_ctrl_b <= wr_byte & acr_pkg::ACR_CTRL_B_MASK;
    end
  end

  // Upper written bits dropped by the field width
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      trigger_source_sel <= acr_pkg::ACR_TRIG_RST;
    end else if (wr_trig) begin
      trigger_source_sel <= wr_byte[acr_pkg::ACR_SEL_W-1:0]; // [RQ1] [RQ2]
    end
  end

  // No reset on purpose: result bytes must survive the system reset
  always_ff @(posedge clk_in) begin
    result_high_byte <= next_result_high_byte; // [RQ9]
    result_low_byte  <= next_result_low_byte; // [RQ9]
  end

  acr_edge_sel u_edge_sel (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .sources_in (trig_sources_in),
    .sel_in     (trigger_source_sel),
    .start_out  (conv_start_out)
  );

  assign converter_on_out           = converter_ctrl_a[acr_pkg::ACR_CTRL_A_ON_BIT];
  assign channel_sel_out            =
    converter_ctrl_a[acr_pkg::ACR_CTRL_A_CHS_MSB:acr_pkg::ACR_CTRL_A_CHS_LSB];
  assign result_format_sel_out      = fmt_right;
  assign conversion_clock_sel_out   =
    converter_ctrl_b[acr_pkg::ACR_CTRL_B_CLK_MSB:acr_pkg::ACR_CTRL_B_CLK_LSB];
  assign positive_reference_sel_out =
    converter_ctrl_b[acr_pkg::ACR_CTRL_B_REF_MSB:acr_pkg::ACR_CTRL_B_REF_LSB];

  wait_one_cycle_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (req_any && avs_waitrequest_out) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("Waitrequest did not drop for exactly one cycle");

  trig_write_a: assert property ( // [RQ1]
    @(posedge clk_in) disable iff (srst_in)
    wr_trig |=> trigger_source_sel == $past(avs_writedata_in[4:0]))
    else $error("Trigger select did not take the written value");

  trig_read_zero_a: assert property ( // [RQ2]
    @(posedge clk_in) disable iff (srst_in)
    (!avs_waitrequest_out && rd_was_trig) |->
      (avs_readdata_out[31:5] == 27'h0000000 &&
       avs_readdata_out[4:0] == trigger_source_sel))
    else $error("Trigger register read back wrong");

  left_high_a: assert property ( // [RQ4]
    @(posedge clk_in) disable iff (srst_in)
    (conv_in.done && !fmt_right) |=> result_high_byte == $past(conv_in.result[9:2]))
    else $error("Left format high byte wrong");

  left_low_a: assert property ( // [RQ5]
    @(posedge clk_in) disable iff (srst_in)
    (conv_in.done && !fmt_right) |=>
      (result_low_byte[7:6] == $past(conv_in.result[1:0]) && result_low_byte[5:0] == 6'h00))
    else $error("Left format low byte wrong");

  right_high_a: assert property ( // [RQ7]
    @(posedge clk_in) disable iff (srst_in)
    (conv_in.done && fmt_right) |=>
      (result_high_byte[1:0] == $past(conv_in.result[9:8]) && result_high_byte[7:2] == 6'h00))
    else $error("Right format high byte wrong");

  right_low_a: assert property ( // [RQ8]
    @(posedge clk_in) disable iff (srst_in)
    (conv_in.done && fmt_right) |=> result_low_byte == $past(conv_in.result[7:0]))
    else $error("Right format low byte wrong");

  result_hold_a: assert property ( // [RQ9]
    @(posedge clk_in)
    (!conv_in.done && !wr_res_hi && !wr_res_lo) |=>
      ($stable(result_high_byte) && $stable(result_low_byte)))
    else $error("Result byte changed without cause");

  result_sw_write_a: assert property ( // [RQ9]
    @(posedge clk_in) disable iff (srst_in)
    (wr_res_lo && !conv_in.done) |=> result_low_byte == $past(avs_writedata_in[7:0]))
    else $error("Software write to low result byte lost");

  atomic_update_a: assert property ( // [RQ10]
    @(posedge clk_in) disable iff (srst_in)
    conv_in.done |=> {result_high_byte, result_low_byte} == $past(fmt_word))
    else $error("Result bytes not updated together");
endmodule

// ---- dv/acr_regs_test.sv ----
// Self-checking bench for the converter result and trigger registers
`timescale 1ns/100ps
module acr_regs_test;
  logic                             clk_in;
  logic                             srst_in;
  logic [acr_pkg::ACR_ADDR_W-1:0]   avs_address_in;
  logic                             avs_read_in;
  logic                             avs_write_in;
  logic [acr_pkg::ACR_DATA_W-1:0]   avs_writedata_in;
  logic [3:0]                       avs_byteenable_in;
  logic [acr_pkg::ACR_DATA_W-1:0]   avs_readdata_out;
  logic                             avs_waitrequest_out;
  logic [acr_pkg::ACR_SRC_N-1:0]    trig_sources_in;
  acr_pkg::acr_conv_t               conv_in;
  logic                             conv_start_out;
  logic                             converter_on_out;
  logic [5:0]                       channel_sel_out;
  logic [2:0]                       conversion_clock_sel_out;
  logic [1:0]                       positive_reference_sel_out;
  logic                             result_format_sel_out;
  int                               bad_count;
  int                               comparisons;
  int                               cycles;
  logic [31:0]                      rd;

  acr_regs acr_regs_i (
    .clk_in                     (clk_in),
    .srst_in                    (srst_in),
    .avs_address_in             (avs_address_in),
    .avs_read_in                (avs_read_in),
    .avs_write_in               (avs_write_in),
    .avs_writedata_in           (avs_writedata_in),
    .avs_byteenable_in          (avs_byteenable_in),
    .avs_readdata_out           (avs_readdata_out),
    .avs_waitrequest_out        (avs_waitrequest_out),
    .trig_sources_in            (trig_sources_in),
    .conv_in                    (conv_in),
    .conv_start_out             (conv_start_out),
    .converter_on_out           (converter_on_out),
    .channel_sel_out            (channel_sel_out),
    .result_format_sel_out      (result_format_sel_out),
    .conversion_clock_sel_out   (conversion_clock_sel_out),
    .positive_reference_sel_out (positive_reference_sel_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Ceiling well above the roughly two hundred cycles the tests need
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h00000000, got}, {31'h00000000, exp});
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [7:0] d,
                          input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address_in    <= a;
    avs_writedata_in  <= {24'h000000, d};
    avs_byteenable_in <= be;
    if (wr) avs_write_in <= 1'b1;
    else avs_read_in <= 1'b1;
    // Only the bench ceiling ends a hung wait
    do begin
      @(posedge clk_in);
      n = n + 1;
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    check_word(n, 32'h00000002);
    @(posedge clk_in);
  endtask

  task automatic bus_write(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, be, q);
  endtask

  task automatic bus_read(input logic [4:0] a, output logic [31:0] q);
    bus_xfer(1'b0, a, 8'h00, 4'hF, q);
  endtask

  // Counted in the scenario itself, so no second process races on the tally
  task automatic count_starts(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge clk_in);
      if (conv_start_out === 1'b1) cnt = cnt + 1;
    end
  endtask

  // Control fields reach their outputs; unimplemented bits read zero
  task automatic test_controls();
    bus_write(acr_pkg::ACR_OFS_CTRL_A, 8'hFF, 4'h1);
    bus_write(acr_pkg::ACR_OFS_CTRL_B, 8'hFF, 4'h1);
    check_bit(converter_on_out, 1'b1);
    check_word({26'h0000000, channel_sel_out}, 32'h0000003F);
    check_word({29'h00000000, conversion_clock_sel_out}, 32'h00000007);
    check_word({30'h00000000, positive_reference_sel_out}, 32'h00000003);
    check_bit(result_format_sel_out, 1'b1);
    bus_read(acr_pkg::ACR_OFS_CTRL_A, rd);
    check_word(rd, 32'h000000FD);
    bus_read(acr_pkg::ACR_OFS_CTRL_B, rd);
    check_word(rd, 32'h000000F3);
    bus_write(acr_pkg::ACR_OFS_CTRL_A, 8'h00, 4'h1);
    check_bit(converter_on_out, 1'b0);
    $display("Test control registers done");
  endtask

  task automatic test_trigger_reg();
    bus_read(acr_pkg::ACR_OFS_TRIG, rd);
    check_word(rd, 32'h00000000);
    bus_write(acr_pkg::ACR_OFS_TRIG, 8'hFF, 4'hF);
    bus_read(acr_pkg::ACR_OFS_TRIG, rd);
    check_word(rd, 32'h0000001F);
    bus_write(acr_pkg::ACR_OFS_TRIG, 8'h0A, 4'hE);
    bus_read(acr_pkg::ACR_OFS_TRIG, rd);
    check_word(rd, 32'h0000001F);
    bus_read(5'h14, rd);
    check_word(rd, 32'h00000000);
    $display("Test trigger register done");
  endtask

  // One start per rising edge, a held level never restarts
  task automatic test_edges();
    logic [4:0] srcs [3];
    int         cnt;
    srcs = '{5'h00, 5'h0D, 5'h1F};
    foreach (srcs[k]) begin
      bus_write(acr_pkg::ACR_OFS_TRIG, {3'h7, srcs[k]}, 4'h1);
      trig_sources_in[srcs[k]] <= 1'b1;
      @(posedge clk_in);
      check_bit(conv_start_out, 1'b0);
      @(posedge clk_in);
      check_bit(conv_start_out, 1'b1);
      count_starts(6, cnt);
      check_word(cnt, 32'h00000000);
    end
    // Reselecting a source that is already high must not start
    trig_sources_in <= 32'hFFFFFFFF;
    @(posedge clk_in);
    bus_write(acr_pkg::ACR_OFS_TRIG, 8'h03, 4'h1);
    count_starts(8, cnt);
    check_word(cnt, 32'h00000000);
    trig_sources_in <= 32'h00000000;
    $display("Test trigger edges done");
  endtask

  task automatic conversion(input logic [9:0] r, input logic fmt);
    logic [31:0] hi;
    logic [31:0] lo;
    bus_write(acr_pkg::ACR_OFS_CTRL_B, {fmt, 7'h00}, 4'h1);
    check_bit(result_format_sel_out, fmt);
    conv_in.result <= r;
    conv_in.done   <= 1'b1;
    @(posedge clk_in);
    conv_in.done   <= 1'b0;
    @(posedge clk_in);
    bus_read(acr_pkg::ACR_OFS_RES_HI, hi);
    bus_read(acr_pkg::ACR_OFS_RES_LO, lo);
    if (!fmt) begin
      check_word(hi, {24'h000000, r[9:2]});
      check_word(lo, {24'h000000, r[1:0], 6'h00});
      check_word(lo & 32'h000000C0, {24'h000000, r[1:0], 6'h00});
    end else begin
      check_word(hi, {24'h000000, 6'h00, r[9:8]});
      check_word(lo, {24'h000000, r[7:0]});
    end
  endtask

  task automatic test_formats();
    logic [9:0] vals [3];
    vals = '{10'h3FF, 10'h2A5, 10'h15A};
    foreach (vals[k]) begin
      conversion(vals[k], 1'b0);
      conversion(vals[k], 1'b1);
    end
    $display("Test result formats done");
  endtask

  // Result bytes are writable and survive the synchronous reset
  task automatic test_result_retain();
    bus_write(acr_pkg::ACR_OFS_RES_HI, 8'hA5, 4'h1);
    bus_write(acr_pkg::ACR_OFS_RES_LO, 8'h3C, 4'h1);
    bus_write(acr_pkg::ACR_OFS_CTRL_B, 8'h80, 4'h1);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    bus_read(acr_pkg::ACR_OFS_RES_HI, rd);
    check_word(rd, 32'h000000A5);
    bus_read(acr_pkg::ACR_OFS_RES_LO, rd);
    check_word(rd, 32'h0000003C);
    bus_read(acr_pkg::ACR_OFS_CTRL_B, rd);
    check_word(rd, 32'h00000000);
    $display("Test result retention done");
  endtask

  initial begin
    bad_count         = 0;
    comparisons       = 0;
    cycles            = 0;
    srst_in           = 1'b1;
    avs_address_in    = 5'h00;
    avs_read_in       = 1'b0;
    avs_write_in      = 1'b0;
    avs_writedata_in  = 32'h00000000;
    avs_byteenable_in = 4'h0;
    trig_sources_in   = 32'h00000000;
    conv_in           = '{done: 1'b0, result: 10'h000};
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    test_trigger_reg();
    test_edges();
    test_controls();
    test_formats();
    test_result_retain();
    print_verdict();
  end
endmodule
